// >>> dlc2_control.sv
// Added by the designer: the plain strobed port.
module dlc2_control (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [7:0] regRdData,
    // Channel framing and data-link bit timing
    input wire dlc2_pkg::dlc2_fmt_t framingFmt,
    input wire logic bitTick,
    // Transmit engine side
    input wire logic engineBit,
    output logic txLineBit,
    output logic txMsgOriented,
    output logic txAborting,
    output logic loopLinkActive,
    output logic sfBitsSelect,
    output logic reportSpareFieldTwo,
    output logic [3:0] reportRField,
    // Receive engine side
    input wire logic rxFrameDone,
    input wire logic rxFcsGood,
    input wire logic [15:0] rxMsgSig,
    output logic rxCheckEnable,
    output logic rxStore,
    output logic rxDrop
);
    import dlc2_pkg::*;

    dlc2_tx_if txIf ();

    logic [7:0] rptReg_q;
    logic [7:0] ctlReg_q;
    logic [7:0] rptApp_q;
    logic [7:0] ctlApp_q;
    logic [7:0] rdData_q;
    logic [7:0] statusVal;
    logic [15:0] heldSig_q;
    logic heldValid_q;
    logic lastDiscard_q;
    logic fcsErr_q;
    logic rxStore_q;
    logic rxDrop_q;
    logic fcsBad;
    logic isRepeat;

    // Loop-carrier format is usable only under these two framings
    function automatic logic loopFmtOk(input dlc2_fmt_t fmt);
        return (fmt == DLC2_FMT_LOOP) || (fmt == DLC2_FMT_ESF);
    endfunction

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Software-side copies, written at once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rptReg_q <= DLC2_RST_REPORT;
            ctlReg_q <= DLC2_RST_CTRL;
        end else if (regWrStrobe) begin
            if (regAddr == DLC2_OFS_REPORT) begin
                rptReg_q <= regWrData;
            end
            if (regAddr == DLC2_OFS_CTRL) begin
                ctlReg_q <= regWrData;
            end
        end
    end

    // Applied copies move only on a link bit boundary, avoiding mid-bit glitches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rptApp_q <= DLC2_RST_REPORT;
            ctlApp_q <= DLC2_RST_CTRL;
        end else if (bitTick) begin
            rptApp_q <= rptReg_q;
            ctlApp_q <= ctlReg_q;
        end
    end

    // Status reflects applied state and last receive outcome
    always_comb begin
        statusVal = 8'h00;
        statusVal[DLC2_STA_LOOP_ACTIVE] = loopLinkActive;
        statusVal[DLC2_STA_ABORTING] = txAborting;
        statusVal[DLC2_STA_LAST_DISCARD] = lastDiscard_q;
        statusVal[DLC2_STA_FCS_ERR] = fcsErr_q;
    end

    // Read data stand one cycle only; unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= 8'h00;
        end else if (regRdStrobe) begin
            case (regAddr)
                DLC2_OFS_REPORT: rdData_q <= rptReg_q;
                DLC2_OFS_CTRL: rdData_q <= ctlReg_q;
                DLC2_OFS_STATUS: rdData_q <= statusVal;
                default: rdData_q <= 8'h00;
            endcase
        end else begin
            rdData_q <= 8'h00;
        end
    end

    assign regRdData = rdData_q;

    // ------------------------------------------------------------
    // Transmit controls
    // ------------------------------------------------------------
    // Report fields straight from applied register
    assign reportSpareFieldTwo = rptApp_q[DLC2_RPT_SPARE2];
    assign reportRField = rptApp_q[DLC2_RPT_RFIELD_LO +: DLC2_RPT_RFIELD_W];

    // Enable ignored outside the two permitted framings
    assign loopLinkActive = ctlApp_q[DLC2_CTL_LOOP_EN] && loopFmtOk(framingFmt);
    assign sfBitsSelect = !loopLinkActive;

    assign txMsgOriented = ctlApp_q[DLC2_CTL_MSG_TYPE];

    // Abort generator hookup
    assign txIf.bitTick = bitTick;
    assign txIf.msgOriented = ctlApp_q[DLC2_CTL_MSG_TYPE];
    assign txIf.autoAbortDis = ctlApp_q[DLC2_CTL_AUTO_ABORT_DIS];
    assign txIf.forceAbort = ctlApp_q[DLC2_CTL_FORCE_ABORT];
    assign txIf.engineBit = engineBit;
    assign txLineBit = txIf.lineBit;
    assign txAborting = txIf.aborting;

    dlc2_abort_gen abortGen (
        .clk(clk),
        .reset_n(reset_n),
        .tx(txIf.gen)
    );

    // ------------------------------------------------------------
    // Receive filtering
    // ------------------------------------------------------------
    assign rxCheckEnable = !ctlApp_q[DLC2_CTL_RX_CHECK_DIS];
    assign fcsBad = rxCheckEnable && !rxFcsGood;
    assign isRepeat = ctlApp_q[DLC2_CTL_AUTO_DISCARD] && heldValid_q
        && (rxMsgSig == heldSig_q);

    // Keep or drop each finished frame; kept frames become the held one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxStore_q <= 1'b0;
            rxDrop_q <= 1'b0;
            heldSig_q <= 16'h0000;
            heldValid_q <= 1'b0;
            lastDiscard_q <= 1'b0;
            fcsErr_q <= 1'b0;
        end else begin
            rxStore_q <= rxFrameDone && !fcsBad && !isRepeat;
            rxDrop_q <= rxFrameDone && (fcsBad || isRepeat);
            if (rxFrameDone) begin
                lastDiscard_q <= !fcsBad && isRepeat;
                fcsErr_q <= fcsBad;
                if (!fcsBad && !isRepeat) begin
                    heldSig_q <= rxMsgSig;
                    heldValid_q <= 1'b1;
                end
            end
        end
    end

    assign rxStore = rxStore_q;
    assign rxDrop = rxDrop_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_spare_follows;
        @(posedge clk) disable iff (!reset_n)
        bitTick |=> reportSpareFieldTwo == $past(rptReg_q[DLC2_RPT_SPARE2]);
    endproperty
    a_spare_follows: assert property (p_spare_follows) else $error("spare bit not applied");

    property p_rfield_follows;
        @(posedge clk) disable iff (!reset_n)
        bitTick |=> reportRField == $past(rptReg_q[DLC2_RPT_RFIELD_LO +: DLC2_RPT_RFIELD_W]);
    endproperty
    a_rfield_follows: assert property (p_rfield_follows) else $error("R field not applied");

    property p_loop_fmt;
        @(posedge clk) disable iff (!reset_n)
        loopLinkActive |-> framingFmt == DLC2_FMT_LOOP || framingFmt == DLC2_FMT_ESF;
    endproperty
    a_loop_fmt: assert property (p_loop_fmt) else $error("loop link in wrong framing");

    property p_loop_sf;
        @(posedge clk) disable iff (!reset_n)
        bitTick |=> sfBitsSelect == !($past(ctlReg_q[DLC2_CTL_LOOP_EN])
            && (framingFmt == DLC2_FMT_LOOP || framingFmt == DLC2_FMT_ESF));
    endproperty
    a_loop_sf: assert property (p_loop_sf) else $error("SF select wrong");

    property p_hold_between_ticks;
        @(posedge clk) disable iff (!reset_n)
        !bitTick |=> $stable(txMsgOriented) && $stable(reportRField);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("applied off tick");

    property p_fcs_drop;
        @(posedge clk) disable iff (!reset_n)
        rxFrameDone && !rxFcsGood && rxCheckEnable |=> rxDrop && !rxStore;
    endproperty
    a_fcs_drop: assert property (p_fcs_drop) else $error("bad FCS frame kept");

    property p_no_check;
        @(posedge clk) disable iff (!reset_n)
        rxFrameDone && !rxCheckEnable && !isRepeat |=> rxStore;
    endproperty
    a_no_check: assert property (p_no_check) else $error("frame dropped with check off");

    property p_repeat_drop;
        @(posedge clk) disable iff (!reset_n)
        rxFrameDone && !fcsBad && !isRepeat ##1 rxFrameDone && $stable(rxMsgSig)
            && ctlApp_q[DLC2_CTL_AUTO_DISCARD] && $stable(ctlApp_q) |=> rxDrop && !rxStore;
    endproperty
    a_repeat_drop: assert property (p_repeat_drop) else $error("repeat not discarded");

    property p_msg_type;
        @(posedge clk) disable iff (!reset_n)
        bitTick |=> txMsgOriented == $past(ctlReg_q[DLC2_CTL_MSG_TYPE]);
    endproperty
    a_msg_type: assert property (p_msg_type) else $error("message type not applied");

    c_repeat: cover property (@(posedge clk) disable iff (!reset_n) rxDrop && lastDiscard_q);
    c_loop: cover property (@(posedge clk) disable iff (!reset_n) loopLinkActive);
    c_read_ctl: cover property (@(posedge clk) disable iff (!reset_n)
        regRdStrobe && regAddr == DLC2_OFS_CTRL);
endmodule

// >>> dlc2_pkg.sv
package dlc2_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] DLC2_OFS_REPORT = 16'h0142;
    localparam logic [15:0] DLC2_OFS_CTRL = 16'h0143;
    localparam logic [15:0] DLC2_OFS_STATUS = 16'h0144;

    localparam logic [7:0] DLC2_RST_REPORT = 8'h00;
    localparam logic [7:0] DLC2_RST_CTRL = 8'h00;

    // Report register fields
    localparam int DLC2_RPT_SPARE2 = 4;
    localparam int DLC2_RPT_RFIELD_LO = 0;
    localparam int DLC2_RPT_RFIELD_W = 4;
    localparam int DLC2_RPT_USED_W = 5;

    // Control register fields
    localparam int DLC2_CTL_LOOP_EN = 7;
    localparam int DLC2_CTL_AUTO_ABORT_DIS = 6;
    localparam int DLC2_CTL_RX_CHECK_DIS = 5;
    localparam int DLC2_CTL_AUTO_DISCARD = 4;
    localparam int DLC2_CTL_FORCE_ABORT = 3;
    localparam int DLC2_CTL_MSG_TYPE = 0;

    // Status register fields
    localparam int DLC2_STA_LOOP_ACTIVE = 0;
    localparam int DLC2_STA_ABORTING = 1;
    localparam int DLC2_STA_LAST_DISCARD = 2;
    localparam int DLC2_STA_FCS_ERR = 3;

    // ------------------------------------------------------------
    // Abort timing and message digest
    // ------------------------------------------------------------
    localparam logic [2:0] DLC2_ABORT_ONES = 3'h7;
    localparam int DLC2_SIG_W = 16;

    // Channel framing formats
    typedef enum logic [1:0] {
        DLC2_FMT_SF = 2'b00,
        DLC2_FMT_ESF = 2'b01,
        DLC2_FMT_LOOP = 2'b10,
        DLC2_FMT_OTHER = 2'b11
    } dlc2_fmt_t;

    // Abort generator states
    typedef enum logic [1:0] {
        DLC2_AB_IDLE = 2'b00,
        DLC2_AB_ZERO = 2'b01,
        DLC2_AB_ONES = 2'b10
    } dlc2_ab_state_t;

endpackage

// >>> dlc2_tx_if.sv
// Transmit path between control block and abort generator
interface dlc2_tx_if;
    logic bitTick;
    logic msgOriented;
    logic autoAbortDis;
    logic forceAbort;
    logic engineBit;
    logic lineBit;
    logic aborting;

    modport ctl (output bitTick, msgOriented, autoAbortDis, forceAbort, engineBit,
        input lineBit, aborting);
    modport gen (input bitTick, msgOriented, autoAbortDis, forceAbort, engineBit,
        output lineBit, aborting);
endinterface

// >>> dlc2_abort_gen.sv
module dlc2_abort_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Transmit path
    dlc2_tx_if.gen tx
);
    import dlc2_pkg::*;

    dlc2_ab_state_t state_q;
    logic prevMos_q;
    logic [2:0] onesCnt_q;
    logic lineBit_q;
    logic switchToBos;

    // ------------------------------------------------------------
    // Abort sequencing
    // ------------------------------------------------------------
    assign switchToBos = tx.bitTick && prevMos_q && !tx.msgOriented;

    // Remember last message type to spot the abrupt switch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevMos_q <= 1'b0;
        end else if (tx.bitTick) begin
            prevMos_q <= tx.msgOriented;
        end
    end

    // Zero then seven ones; a new switch mid-abort restarts it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= DLC2_AB_IDLE;
            onesCnt_q <= 3'h0;
        end else if (switchToBos && !tx.autoAbortDis) begin
            state_q <= DLC2_AB_ZERO;
            onesCnt_q <= 3'h0;
        end else if (tx.bitTick) begin
            case (state_q)
                DLC2_AB_IDLE: begin
                    state_q <= DLC2_AB_IDLE;
                end
                DLC2_AB_ZERO: begin
                    state_q <= DLC2_AB_ONES;
                    onesCnt_q <= 3'h1;
                end
                // Leave on the tick that sends the seventh one, not one tick later
                DLC2_AB_ONES: begin
                    onesCnt_q <= onesCnt_q + 3'h1;
                    if (onesCnt_q + 3'h1 == DLC2_ABORT_ONES) begin
                        state_q <= DLC2_AB_IDLE;
                    end
                end
                default: begin
                    state_q <= DLC2_AB_IDLE;
                end
            endcase
        end
    end

    // Line bit: forced abort wins over everything, then auto abort
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineBit_q <= 1'b1;
        end else if (tx.bitTick) begin
            if (tx.forceAbort) begin
                lineBit_q <= 1'b1;
            end else if (switchToBos && !tx.autoAbortDis) begin
                lineBit_q <= 1'b0;
            end else if (state_q == DLC2_AB_ZERO || state_q == DLC2_AB_ONES) begin
                lineBit_q <= 1'b1;
            end else begin
                lineBit_q <= tx.engineBit;
            end
        end
    end

    assign tx.lineBit = lineBit_q;
    assign tx.aborting = tx.forceAbort || (state_q != DLC2_AB_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_force_ones;
        @(posedge clk) disable iff (!reset_n)
        tx.bitTick && tx.forceAbort |=> tx.lineBit;
    endproperty
    a_force_ones: assert property (p_force_ones) else $error("forced abort not ones");

    property p_auto_zero;
        @(posedge clk) disable iff (!reset_n)
        switchToBos && !tx.autoAbortDis && !tx.forceAbort |=> !tx.lineBit;
    endproperty
    a_auto_zero: assert property (p_auto_zero) else $error("abort did not start with zero");

    property p_auto_len;
        @(posedge clk) disable iff (!reset_n)
        $rose(state_q == DLC2_AB_ONES) |-> onesCnt_q == 3'h1;
    endproperty
    a_auto_len: assert property (p_auto_len) else $error("abort ones count wrong");

    property p_no_auto_when_dis;
        @(posedge clk) disable iff (!reset_n)
        switchToBos && tx.autoAbortDis && state_q == DLC2_AB_IDLE |=> state_q == DLC2_AB_IDLE;
    endproperty
    a_no_auto_when_dis: assert property (p_no_auto_when_dis) else $error("abort sent while disabled");

    c_auto_abort: cover property (@(posedge clk) disable iff (!reset_n)
        state_q == DLC2_AB_ONES && onesCnt_q + 3'h1 == DLC2_ABORT_ONES && tx.bitTick);
    c_force_abort: cover property (@(posedge clk) disable iff (!reset_n)
        tx.forceAbort && tx.bitTick);
endmodule

// >>> dlc2_far_model.sv
module dlc2_far_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bench controls
    input wire logic engSet,
    input wire logic frmGo,
    input wire logic frmGood,
    input wire logic [15:0] frmSig,
    // Link to the block
    input wire logic txLineBit,
    output logic bitTick,
    output logic engineBit,
    output logic rxFrameDone,
    output logic rxFcsGood,
    output logic [15:0] rxMsgSig
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] tickDiv_q;
    int onesSeen;

    // ------------------------------------------------------------
    // Line timing and capture
    // ------------------------------------------------------------
    // Bit boundary every fourth clock; line bit counted as it stands
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickDiv_q <= 2'd0;
            bitTick <= 1'b0;
            onesSeen <= 0;
        end else begin
            tickDiv_q <= tickDiv_q + 2'd1;
            bitTick <= (tickDiv_q == 2'd3);
            if (bitTick && txLineBit) onesSeen <= onesSeen + 1;
        end
    end
    assign engineBit = engSet;

    // ------------------------------------------------------------
    // Received frames
    // ------------------------------------------------------------
    // Outside a frame the verdict and digest invert every cycle, so stale values match only on alternate cycles
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxFrameDone <= 1'b0;
            rxFcsGood <= 1'b0;
            rxMsgSig <= 16'h0000;
        end else if (frmGo) begin
            rxFrameDone <= 1'b1;
            rxFcsGood <= frmGood;
            rxMsgSig <= frmSig;
        end else begin
            rxFrameDone <= 1'b0;
            rxFcsGood <= ~rxFcsGood;
            rxMsgSig <= ~rxMsgSig;
        end
    end
endmodule

// >>> tb_data_link_hdlc2_control.sv
module tb_data_link_hdlc2_control;
    timeunit 1ns;
    timeprecision 1ns;
    import dlc2_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    dlc2_fmt_t framingFmt = DLC2_FMT_ESF;
    logic engSet = 1'b0;
    logic frmGo = 1'b0;
    logic frmGood = 1'b0;
    logic [15:0] frmSig = 16'h0000;
    logic [7:0] regRdData, rd;
    logic bitTick, engineBit, txLineBit, txMsgOriented, txAborting, loopLinkActive;
    logic sfBitsSelect, reportSpareFieldTwo, rxFrameDone, rxFcsGood, rxCheckEnable;
    logic rxStore, rxDrop;
    logic [3:0] reportRField;
    logic [15:0] rxMsgSig;
    int fails = 0;
    int compares = 0;
    int snap;

    always #50 clk = ~clk;

    dlc2_control DUT (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
        .regRdData(regRdData), .framingFmt(framingFmt), .bitTick(bitTick),
        .engineBit(engineBit), .txLineBit(txLineBit), .txMsgOriented(txMsgOriented),
        .txAborting(txAborting), .loopLinkActive(loopLinkActive),
        .sfBitsSelect(sfBitsSelect), .reportSpareFieldTwo(reportSpareFieldTwo),
        .reportRField(reportRField), .rxFrameDone(rxFrameDone), .rxFcsGood(rxFcsGood),
        .rxMsgSig(rxMsgSig), .rxCheckEnable(rxCheckEnable), .rxStore(rxStore),
        .rxDrop(rxDrop));

    dlc2_far_model far (.clk(clk), .reset_n(reset_n), .engSet(engSet), .frmGo(frmGo),
        .frmGood(frmGood), .frmSig(frmSig), .txLineBit(txLineBit), .bitTick(bitTick),
        .engineBit(engineBit), .rxFrameDone(rxFrameDone), .rxFcsGood(rxFcsGood),
        .rxMsgSig(rxMsgSig));

    // ------------------------------------------------------------
    // Bench tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrStrobe <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic regRead(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        regRdStrobe <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdStrobe <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic waitTicks(input int n);
        repeat (n) @(posedge clk iff bitTick);
        #1;
    endtask

    // Settings only apply at a bit boundary, so allow two of them
    task automatic setCtrl(input logic [7:0] d);
        regWrite(DLC2_OFS_CTRL, d);
        waitTicks(2);
    endtask

    task automatic frame(input logic [15:0] s, input logic g, input logic keep);
        @(posedge clk);
        frmGo <= 1'b1;
        frmSig <= s;
        frmGood <= g;
        @(posedge clk);
        frmGo <= 1'b0;
        @(posedge clk);
        #1;
        check("rxStore", {15'd0, rxStore}, {15'd0, keep});
        check("rxDrop", {15'd0, rxDrop}, {15'd0, !keep});
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; give it ample margin
    initial begin
        #2_000_000;
        fails++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check("line idle", {15'd0, txLineBit}, 16'h0001);
        check("sf select", {15'd0, sfBitsSelect}, 16'h0001);
        check("rx check", {15'd0, rxCheckEnable}, 16'h0001);
        regRead(DLC2_OFS_REPORT, rd);
        check("report reset", {8'd0, rd}, {8'd0, DLC2_RST_REPORT});
        regRead(DLC2_OFS_CTRL, rd);
        check("ctrl reset", {8'd0, rd}, {8'd0, DLC2_RST_CTRL});
        regRead(16'h0150, rd);
        check("unmapped", {8'd0, rd}, 16'h0000);
        $display("Test reset done");

        regWrite(DLC2_OFS_REPORT, 8'h15);
        waitTicks(2);
        check("spare two", {15'd0, reportSpareFieldTwo}, 16'h0001);
        check("r field", {12'd0, reportRField}, 16'h0005);
        regWrite(DLC2_OFS_REPORT, 8'hEA);
        waitTicks(2);
        check("spare two", {15'd0, reportSpareFieldTwo}, 16'h0000);
        check("r field", {12'd0, reportRField}, 16'h000A);
        regRead(DLC2_OFS_REPORT, rd);
        check("report rw", {8'd0, rd}, 16'h00EA);
        $display("Test report done");

        setCtrl(8'h80);
        for (int f = 0; f < 4; f++) begin
            @(posedge clk);
            framingFmt <= dlc2_fmt_t'(f);
            #1;
            check("loop link", {15'd0, loopLinkActive}, {15'd0, f == 1 || f == 2});
            check("sf select", {15'd0, sfBitsSelect}, {15'd0, !(f == 1 || f == 2)});
        end
        @(posedge clk);
        framingFmt <= DLC2_FMT_ESF;
        setCtrl(8'h00);
        check("loop link off", {15'd0, loopLinkActive}, 16'h0000);
        $display("Test loop link done");

        frame(16'h1234, 1'b1, 1'b1);
        frame(16'h4321, 1'b0, 1'b0);
        setCtrl(8'h20);
        check("rx check", {15'd0, rxCheckEnable}, 16'h0000);
        frame(16'h5678, 1'b0, 1'b1);
        setCtrl(8'h30);
        frame(16'h5678, 1'b1, 1'b0);
        frame(16'h9ABC, 1'b1, 1'b1);
        // Back-to-back identical frames: first kept, second a repeat
        @(posedge clk);
        frmGo <= 1'b1;
        frmSig <= 16'hC3C3;
        frmGood <= 1'b1;
        repeat (2) @(posedge clk);
        frmGo <= 1'b0;
        #1;
        check("pair keep", {15'd0, rxStore}, 16'h0001);
        @(posedge clk);
        #1;
        check("pair drop", {15'd0, rxDrop}, 16'h0001);
        check("pair store", {15'd0, rxStore}, 16'h0000);
        regRead(DLC2_OFS_STATUS, rd);
        check("status repeat", {8'd0, rd}, 16'h0004);
        setCtrl(8'h20);
        frame(16'h9ABC, 1'b1, 1'b1);
        $display("Test receive done");

        @(posedge clk);
        engSet <= 1'b1;
        setCtrl(8'h01);
        waitTicks(1);
        check("msg type", {15'd0, txMsgOriented}, 16'h0001);
        check("engine bit", {15'd0, txLineBit}, 16'h0001);
        @(posedge clk);
        engSet <= 1'b0;
        waitTicks(2);
        check("engine bit", {15'd0, txLineBit}, 16'h0000);
        snap = far.onesSeen;
        setCtrl(8'h00);
        waitTicks(10);
        check("auto abort ones", 16'(far.onesSeen - snap), 16'h0007);
        check("msg type", {15'd0, txMsgOriented}, 16'h0000);
        setCtrl(8'h41);
        snap = far.onesSeen;
        setCtrl(8'h40);
        waitTicks(10);
        check("no abort ones", 16'(far.onesSeen - snap), 16'h0000);
        setCtrl(8'h08);
        check("forced abort", {15'd0, txAborting}, 16'h0001);
        snap = far.onesSeen;
        waitTicks(8);
        check("forced ones", 16'(far.onesSeen - snap), 16'h0008);
        setCtrl(8'h00);
        check("forced abort", {15'd0, txAborting}, 16'h0000);
        check("line normal", {15'd0, txLineBit}, 16'h0000);
        $display("Test transmit done");
        print_verdict();
    end
endmodule
